// >>> src/sfoc_output_ctrl.sv
// shared package and safety output decision: function modes, routing, start-up
// Notes on behaviour
// - single mode: ten pairs, drive only pair a
// - four field: two protective, two warning fields
// - four field: pair index a also selects b
// - protective field a violated: pair a off
// - protective field b: only b clear changes
// - logic signals routed to outputs by setting
// - separate warning signals, also routable to the message and general outputs
// - one resolution per bank, six values
// - outputs off within response time
// - response time shared across the bank
// - start-up behaviour chosen per bank
// - automatic mode: enable without reset request
// - interlock mode: off after power until reset
// - interlock mode: restart automatically after violation
// - valid reset: held 0.12 s to 4 s
package sfoc_pkg;

  // timing: system clock rate and reset button hold window
  localparam int unsigned CLK_KHZ     = 25000;
  localparam int unsigned RST_MIN_MS  = 120;
  localparam int unsigned RST_MAX_MS  = 4000;
  localparam int unsigned RST_MIN_CYC = RST_MIN_MS * CLK_KHZ;  // least time, exact in cycles
  localparam int unsigned RST_MAX_CYC = RST_MAX_MS * CLK_KHZ;  // longest time, exact in cycles
  localparam int          CNT_W       = 27;

  // field pair numbering
  localparam int             PAIR_W     = 4;
  localparam logic [3:0]     PAIR_LAST  = 4'h9;
  localparam logic [3:0]     PAIR_RESET = 4'h0;
  localparam logic [7:0]     CFG_RESET  = 8'h00;

  // resolution values in millimetres
  localparam logic [7:0] RES_MM_30  = 8'h1E;
  localparam logic [7:0] RES_MM_40  = 8'h28;
  localparam logic [7:0] RES_MM_50  = 8'h32;
  localparam logic [7:0] RES_MM_60  = 8'h3C;
  localparam logic [7:0] RES_MM_70  = 8'h46;
  localparam logic [7:0] RES_MM_150 = 8'h96;

  typedef enum logic [2:0] {RES_30, RES_40, RES_50, RES_60, RES_70, RES_150} sfoc_res_t;
  typedef enum logic {MODE_SINGLE, MODE_FOUR} sfoc_fmode_t;
  typedef enum logic {START_AUTO, START_INTERLOCK} sfoc_start_t;
  typedef enum logic [1:0] {SIG_B_CLEAR, SIG_WARN_A, SIG_WARN_B, SIG_SAFE_A} sfoc_sig_t;

  // one configuration bank, shared by all of its field pairs
  typedef struct packed {
    sfoc_res_t   res;        // detection resolution
    logic [7:0]  max_speed;  // max vehicle speed, 0.1 m/s units
    logic [7:0]  resp_ms;    // response time in ms
    sfoc_start_t start;      // start-up behaviour
  } sfoc_bank_t;

  // field violations from the evaluation logic
  typedef struct packed {
    logic pf_a;  // protective field a
    logic pf_b;  // protective field b
    logic wf_a;  // warning field a
    logic wf_b;  // warning field b
  } sfoc_viol_t;

  // settings handed to the evaluation logic
  typedef struct packed {
    logic [3:0] pair_a;     // active pair of function a
    logic [3:0] pair_b;     // active pair of function b
    logic       pair_b_en;  // function b monitored
    logic [7:0] res_mm;     // resolution in mm
    logic [7:0] max_speed;  // max vehicle speed
    logic [7:0] resp_ms;    // response time
  } sfoc_eval_cfg_t;

endpackage : sfoc_pkg

`timescale 1ns/100ps
`default_nettype none

module sfoc_output_ctrl #(
  parameter int unsigned RST_MIN_CYC = sfoc_pkg::RST_MIN_CYC,
  parameter int unsigned RST_MAX_CYC = sfoc_pkg::RST_MAX_CYC
) (
  input  wire logic                     clk_sys,                  // system clock, 25 MHz
  input  wire logic                     srst,                     // sync reset, power-up
  input  wire sfoc_pkg::sfoc_viol_t     viol,                     // field violations
  input  wire sfoc_pkg::sfoc_fmode_t    func_mode,                // single or four field
  input  wire logic [3:0]               pair_sel_pin,             // field pair index pins
  input  wire sfoc_pkg::sfoc_bank_t     bank,                     // active bank settings
  input  wire sfoc_pkg::sfoc_sig_t [2:0] route_sel,               // source of msg, gen out, gen io
  input  wire logic                     reset_button_pin,         // reset button pin
  output var  logic [1:0]               safety_output_pair_a,     // safety pair, 11 = on
  output var  logic                     non_safe_message_output,  // routed message output
  output var  logic                     general_output_one,       // routed general output
  output var  logic                     general_io_one,           // routed general io
  output var  logic                     warn_field_a_violation,   // warning a violated
  output var  logic                     warn_field_b_violation,   // warning b violated
  output var  logic                     b_clear,                  // function b field clear
  output var  logic                     interlock_active,         // waiting for reset
  output var  sfoc_pkg::sfoc_eval_cfg_t eval_cfg                  // settings to evaluation
);

  typedef enum logic {ST_LOCKED, ST_ARMED} sfoc_state_t;

  // resolution code to millimetres
  function automatic logic [7:0] res_to_mm(input sfoc_pkg::sfoc_res_t r);
    case (r)
      sfoc_pkg::RES_30:  res_to_mm = sfoc_pkg::RES_MM_30;
      sfoc_pkg::RES_40:  res_to_mm = sfoc_pkg::RES_MM_40;
      sfoc_pkg::RES_50:  res_to_mm = sfoc_pkg::RES_MM_50;
      sfoc_pkg::RES_60:  res_to_mm = sfoc_pkg::RES_MM_60;
      sfoc_pkg::RES_70:  res_to_mm = sfoc_pkg::RES_MM_70;
      default:           res_to_mm = sfoc_pkg::RES_MM_150;
    endcase
  endfunction : res_to_mm

  // pick one logic signal for a switching output
  function automatic logic route_pick(input sfoc_pkg::sfoc_sig_t s, input logic [3:0] sig);
    case (s)
      sfoc_pkg::SIG_B_CLEAR: route_pick = sig[0];
      sfoc_pkg::SIG_WARN_A:  route_pick = sig[1];
      sfoc_pkg::SIG_WARN_B:  route_pick = sig[2];
      default:               route_pick = sig[3];
    endcase
  endfunction : route_pick

  logic                     reset_valid;
  logic [3:0]               sel_s1_q, sel_s2_q;
  sfoc_state_t              state_q, state_d;
  logic                     safe_q, safe_d;
  logic                     bclr_q, bclr_d, wa_q, wa_d, wb_q, wb_d;
  logic                     lock_q, lock_d;
  logic [2:0]               gen_q, gen_d;
  sfoc_pkg::sfoc_eval_cfg_t cfg_q, cfg_d;

  // timed reset button qualifier
  sfoc_reset_timer #(
    .MIN_CYC (RST_MIN_CYC),
    .MAX_CYC (RST_MAX_CYC)
  ) u_reset_timer (
    .clk_sys          (clk_sys),
    .srst             (srst),
    .reset_button_pin (reset_button_pin),
    .reset_valid      (reset_valid)
  );

  // start-up state: locked until released by mode or valid reset
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_LOCKED: begin
        if (bank.start == sfoc_pkg::START_AUTO) state_d = ST_ARMED;
        else if (reset_valid) state_d = ST_ARMED;
      end
      default: state_d = ST_ARMED;
    endcase
  end

  // output decisions and bank settings
  always_comb begin
    logic [3:0] sig;
    sig    = 4'h0;
    cfg_d  = cfg_q;
    safe_d = (state_q == ST_ARMED) && !viol.pf_a;
    lock_d = (state_q == ST_LOCKED);
    if (func_mode == sfoc_pkg::MODE_FOUR) begin
      bclr_d = !viol.pf_b;
      wb_d   = viol.wf_b;
    end else begin
      bclr_d = 1'b1;
      wb_d   = 1'b0;
    end
    wa_d = viol.wf_a;
    if (sel_s2_q <= sfoc_pkg::PAIR_LAST) cfg_d.pair_a = sel_s2_q;
    cfg_d.pair_b    = cfg_d.pair_a;
    cfg_d.pair_b_en = (func_mode == sfoc_pkg::MODE_FOUR);
    cfg_d.res_mm    = res_to_mm(bank.res);
    cfg_d.max_speed = bank.max_speed;
    cfg_d.resp_ms   = bank.resp_ms;
    sig = {safe_d, wb_d, wa_d, bclr_d};
    for (int i = 0; i < 3; i++) begin
      gen_d[i] = route_pick(route_sel[i], sig);
    end
  end

  // registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_s1_q <= sfoc_pkg::PAIR_RESET;
      sel_s2_q <= sfoc_pkg::PAIR_RESET;
      state_q  <= ST_LOCKED;
      safe_q   <= 1'b0;
      lock_q   <= 1'b1;
      bclr_q   <= 1'b0;
      wa_q     <= 1'b0;
      wb_q     <= 1'b0;
      gen_q    <= 3'h0;
      cfg_q    <= '{pair_a: sfoc_pkg::PAIR_RESET, pair_b: sfoc_pkg::PAIR_RESET, pair_b_en: 1'b0,
                    res_mm: sfoc_pkg::CFG_RESET, max_speed: sfoc_pkg::CFG_RESET, resp_ms: sfoc_pkg::CFG_RESET};
    end else begin
      sel_s1_q <= pair_sel_pin;
      sel_s2_q <= sel_s1_q;
      state_q  <= state_d;
      safe_q   <= safe_d;
      lock_q   <= lock_d;
      bclr_q   <= bclr_d;
      wa_q     <= wa_d;
      wb_q     <= wb_d;
      gen_q    <= gen_d;
      cfg_q    <= cfg_d;
    end
  end

  // outputs straight from flip-flops
  assign safety_output_pair_a    = {safe_q, safe_q};
  assign b_clear                 = bclr_q;
  assign warn_field_a_violation  = wa_q;
  assign warn_field_b_violation  = wb_q;
  assign non_safe_message_output = gen_q[0];
  assign general_output_one      = gen_q[1];
  assign general_io_one          = gen_q[2];
  assign interlock_active        = lock_q;
  assign eval_cfg                = cfg_q;

  a_pf_a_off: assert property (@(posedge clk_sys) disable iff (srst)
    viol.pf_a |=> safety_output_pair_a == 2'b00) else $error("pair a on with protective field a violated");
  a_resp_bound: assert property (@(posedge clk_sys) disable iff (srst)
    viol.pf_a [*2] |-> safety_output_pair_a == 2'b00) else $error("pair a not off in time");
  a_pf_b_no_safe: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_ARMED && viol.pf_b && !viol.pf_a) |=> safety_output_pair_a == 2'b11)
    else $error("function b violation switched pair a");
  a_b_clear_track: assert property (@(posedge clk_sys) disable iff (srst)
    (func_mode == sfoc_pkg::MODE_FOUR) |=> b_clear == !$past(viol.pf_b)) else $error("b clear wrong");
  a_pair_b_follow: assert property (@(posedge clk_sys) disable iff (srst)
    eval_cfg.pair_b_en |-> eval_cfg.pair_b == eval_cfg.pair_a) else $error("pair b not following a");
  a_single_a_only: assert property (@(posedge clk_sys) disable iff (srst)
    (func_mode == sfoc_pkg::MODE_SINGLE) |=> !eval_cfg.pair_b_en && eval_cfg.pair_a <= sfoc_pkg::PAIR_LAST
      && !warn_field_b_violation) else $error("single mode uses function b");
  a_warn_a_route: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> warn_field_a_violation == $past(viol.wf_a)) else $error("warning a lost");
  a_auto_start: assert property (@(posedge clk_sys)
    $fell(srst) && bank.start == sfoc_pkg::START_AUTO && !viol.pf_a ##1 !viol.pf_a
      |=> safety_output_pair_a == 2'b11) else $error("automatic start did not enable");
  a_interlock_hold: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_LOCKED && bank.start == sfoc_pkg::START_INTERLOCK && !reset_valid)
      |=> safety_output_pair_a == 2'b00 && interlock_active) else $error("interlock released without reset");
  a_auto_restart: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_ARMED && $past(viol.pf_a) && !viol.pf_a) |=> safety_output_pair_a == 2'b11)
    else $error("no automatic restart");
  a_bank_res: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> eval_cfg.res_mm == res_to_mm($past(bank.res)) && eval_cfg.resp_ms == $past(bank.resp_ms))
    else $error("bank settings not applied");

endmodule : sfoc_output_ctrl

`default_nettype wire

// >>> src/sfoc_reset_timer.sv
// timed reset button qualifier: hold length judged on release
`timescale 1ns/100ps
`default_nettype none

module sfoc_reset_timer #(
  parameter int unsigned MIN_CYC = sfoc_pkg::RST_MIN_CYC,
  parameter int unsigned MAX_CYC = sfoc_pkg::RST_MAX_CYC
) (
  input  wire logic clk_sys,           // system clock
  input  wire logic srst,              // sync reset, active high
  input  wire logic reset_button_pin,  // raw reset button, active high
  output var  logic reset_valid        // one-cycle pulse on valid release
);

  localparam logic [sfoc_pkg::CNT_W-1:0] MIN_C = sfoc_pkg::CNT_W'(MIN_CYC);
  localparam logic [sfoc_pkg::CNT_W-1:0] MAX_C = sfoc_pkg::CNT_W'(MAX_CYC);
  localparam logic [sfoc_pkg::CNT_W-1:0] SAT_C = sfoc_pkg::CNT_W'(MAX_CYC + 1);

  logic                      s1_q, s2_q, prev_q, prev_d, valid_q, valid_d;
  logic [sfoc_pkg::CNT_W-1:0] cnt_q, cnt_d;

  // hold counter, saturating above the window; judge on release
  always_comb begin
    prev_d  = s2_q;
    cnt_d   = cnt_q;
    if (s2_q) begin
      if (cnt_q < SAT_C) cnt_d = cnt_q + 1'b1;
    end else begin
      cnt_d = '0;
    end
    valid_d = prev_q && !s2_q && (cnt_q >= MIN_C) && (cnt_q <= MAX_C);
  end

  // synchroniser and state registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      prev_q  <= 1'b0;
      cnt_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      s1_q    <= reset_button_pin;
      s2_q    <= s1_q;
      prev_q  <= prev_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
    end
  end

  assign reset_valid = valid_q;

  a_short_press: assert property (@(posedge clk_sys) disable iff (srst)
    (prev_q && !s2_q && cnt_q < MIN_C) |=> !valid_q) else $error("short reset press accepted");

endmodule : sfoc_reset_timer

`default_nettype wire

// >>> verification/sfoc_button_model.sv
// operator reset button model for the start interlock
`timescale 1ns/100ps
`default_nettype none

module sfoc_button_model (
  input  wire logic clk_sys,          // system clock
  output var  logic reset_button_pin  // button level, high while pressed
);
  // button released at power-up
  initial reset_button_pin = 1'b0;

  // hold for n cycles, then release to the pull-down level
  task automatic press(input int unsigned n);
    @(posedge clk_sys);
    reset_button_pin <= 1'b1;
    repeat (n) @(posedge clk_sys);
    reset_button_pin <= 1'b0;
  endtask : press
endmodule : sfoc_button_model

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the safety output decision block
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int unsigned MIN_C = 12;
  localparam int unsigned MAX_C = 400;

  logic                      clk_sys;
  logic                      srst;
  sfoc_pkg::sfoc_viol_t      viol;
  sfoc_pkg::sfoc_fmode_t     func_mode;
  logic [3:0]                pair_sel_pin;
  sfoc_pkg::sfoc_bank_t      bank;
  sfoc_pkg::sfoc_sig_t [2:0] route_sel;
  wire logic                 reset_button_pin;
  logic [1:0]                safe_a;
  logic                      msg_o, gen_o, gio_o, wa_o, wb_o, bclr_o, lock_o;
  sfoc_pkg::sfoc_eval_cfg_t  eval_cfg;
  int                        n_mismatch;
  int                        check_count;
  logic [3:0]                sig;
  logic [7:0]                res_tab [6] = '{sfoc_pkg::RES_MM_30, sfoc_pkg::RES_MM_40, sfoc_pkg::RES_MM_50,
                                             sfoc_pkg::RES_MM_60, sfoc_pkg::RES_MM_70, sfoc_pkg::RES_MM_150};

  sfoc_output_ctrl #(.RST_MIN_CYC(MIN_C), .RST_MAX_CYC(MAX_C)) sfoc_output_ctrl_i (
    .clk_sys(clk_sys), .srst(srst), .viol(viol), .func_mode(func_mode), .pair_sel_pin(pair_sel_pin),
    .bank(bank), .route_sel(route_sel), .reset_button_pin(reset_button_pin),
    .safety_output_pair_a(safe_a), .non_safe_message_output(msg_o), .general_output_one(gen_o),
    .general_io_one(gio_o), .warn_field_a_violation(wa_o), .warn_field_b_violation(wb_o),
    .b_clear(bclr_o), .interlock_active(lock_o), .eval_cfg(eval_cfg));

  sfoc_button_model sfoc_button_model_i (.clk_sys(clk_sys), .reset_button_pin(reset_button_pin));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic settle(input int n);
    cyc(n);
    #1;
  endtask : settle

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk_vec

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // power-up reset with a chosen start-up behaviour
  task automatic reset_dut(input sfoc_pkg::sfoc_start_t st);
    cyc(1);
    bank.start <= st;
    srst <= 1'b1;
    cyc(6);
    srst <= 1'b0;
    settle(3);
  endtask : reset_dut

  // four field violation mix, then every route code on every output
  task automatic mix(input logic [3:0] v);
    cyc(1);
    viol <= v;
    sig = {~v[3], v[0], v[1], ~v[2]};
    settle(1);
    chk_bit(bclr_o, ~v[2], "b clear");
    chk_bit(wa_o, v[1], "warn a");
    chk_bit(wb_o, v[0], "warn b");
    chk_vec(8'(safe_a), 8'h03, "pair a untouched by b");
    for (int c = 0; c < 4; c++) begin
      cyc(1);
      for (int k = 0; k < 3; k++) route_sel[k] <= sfoc_pkg::sfoc_sig_t'((c + k) % 4);
      settle(1);
      chk_bit(msg_o, sig[c % 4], "message output");
      chk_bit(gen_o, sig[(c + 1) % 4], "general output");
      chk_bit(gio_o, sig[(c + 2) % 4], "general io");
    end
  endtask : mix

  // main sequence
  initial begin
    n_mismatch = 0;
    check_count = 0;
    srst <= 1'b1;
    viol <= 4'h0;
    func_mode <= sfoc_pkg::MODE_FOUR;
    pair_sel_pin <= 4'h0;
    bank <= '0;
    route_sel <= {3{sfoc_pkg::SIG_B_CLEAR}};
    reset_dut(sfoc_pkg::START_AUTO);
    chk_vec(8'(safe_a), 8'h03, "auto start");
    chk_bit(lock_o, 1'b0, "auto not locked");
    cyc(1);
    viol.pf_a <= 1'b1;
    settle(1);
    chk_vec(8'(safe_a), 8'h00, "switch-off");
    cyc(1);
    viol.pf_a <= 1'b0;
    settle(2);
    chk_vec(8'(safe_a), 8'h03, "auto restart");
    mix(4'b0110);
    mix(4'b0001);
    // single mode ignores function b
    cyc(1);
    func_mode <= sfoc_pkg::MODE_SINGLE;
    viol <= 4'b0101;
    settle(1);
    chk_bit(bclr_o, 1'b1, "single b clear");
    chk_bit(wb_o, 1'b0, "single warn b");
    chk_vec(8'(safe_a), 8'h03, "single pair a");
    // field pair index, last valid and out of range
    cyc(1);
    func_mode <= sfoc_pkg::MODE_FOUR;
    viol <= 4'h0;
    pair_sel_pin <= 4'h9;
    settle(4);
    chk_vec(8'(eval_cfg.pair_a), 8'h09, "pair a index");
    chk_vec(8'(eval_cfg.pair_b), 8'h09, "pair b follows");
    chk_bit(eval_cfg.pair_b_en, 1'b1, "pair b on");
    cyc(1);
    pair_sel_pin <= 4'hC;
    settle(4);
    chk_vec(8'(eval_cfg.pair_a), 8'h09, "pair index kept");
    // bank settings, every resolution
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      bank.res <= sfoc_pkg::sfoc_res_t'(i);
      bank.max_speed <= 8'(i * 3 + 1);
      bank.resp_ms <= 8'(i * 5 + 2);
      settle(1);
      chk_vec(eval_cfg.res_mm, res_tab[i], "resolution");
      chk_vec(eval_cfg.max_speed, 8'(i * 3 + 1), "vehicle speed");
      chk_vec(eval_cfg.resp_ms, 8'(i * 5 + 2), "response time");
    end
    // start interlock: short, long and minimum presses
    reset_dut(sfoc_pkg::START_INTERLOCK);
    chk_vec(8'(safe_a), 8'h00, "locked at power-up");
    chk_bit(lock_o, 1'b1, "lock shown");
    sfoc_button_model_i.press(MIN_C - 1);
    settle(8);
    chk_vec(8'(safe_a), 8'h00, "short press");
    sfoc_button_model_i.press(MAX_C + 10);
    settle(8);
    chk_vec(8'(safe_a), 8'h00, "long press");
    sfoc_button_model_i.press(MIN_C);
    settle(8);
    chk_vec(8'(safe_a), 8'h03, "valid press");
    chk_bit(lock_o, 1'b0, "lock cleared");
    cyc(1);
    viol.pf_a <= 1'b1;
    settle(1);
    chk_vec(8'(safe_a), 8'h00, "interlock switch-off");
    cyc(1);
    viol.pf_a <= 1'b0;
    settle(2);
    chk_vec(8'(safe_a), 8'h03, "restart without press");
    complete_run();
  end

  // watchdog against a hang
  initial begin
    cyc(20000);
    n_mismatch++;
    complete_run();
  end
endmodule : tb

`default_nettype wire
